// file: design/ldc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ldc_params.svh"
module ldc_top import ldc_pkg::*; #(
    parameter int unsigned BLINK_HALF_CYC = (`LDC_BLINK_2HZ_MS * `LDC_CLK_SYS_KHZ) / 2  // Half period at 2 Hz
) (
    input  wire logic           clk_sys,   // Internal oscillator clock
    input  wire logic           reset,     // Power-on reset, sync high
    input  wire logic           clk_link,  // Link sampling clock
    input  wire logic           sclIn,     // SCL pin level
    input  wire logic           sdaIn,     // SDA pin level
    output logic                sdaOut,    // SDA drive value, always low
    output logic                sdaOe,     // SDA pull-low enable
    output ldc_mode_t           modeCfg,   // Decoded drive mode
    output logic [1:0]          blinkSel,  // Blink rate select
    output logic                blinkBlank,// Blink blank phase
    output logic [8*`LDC_RAM_DEPTH-1:0] segDrive // Segment map, index 4*seg+com
);
    localparam int MW = 8 * `LDC_RAM_DEPTH;  // Segment map width

    // Opcode decoders, shared by FSM and event logic
    function automatic logic isPtr(input logic [7:0] b);
        isPtr = (b[7:5] == `LDC_OP_PTR) && (b[4:0] <= `LDC_PTR_MAX);
    endfunction
    function automatic logic isMode(input logic [7:0] b);
        isMode = (b[7:5] == `LDC_OP_MODE) && !b[`LDC_F_CLR];
    endfunction
    function automatic logic isBlink(input logic [7:0] b);
        isBlink = (b[7:2] == `LDC_OP_BLINK);
    endfunction
    // Pointer advance, wrapping at the top location
    function automatic logic [4:0] nextPtr(input logic [4:0] p);
        nextPtr = (p == `LDC_PTR_MAX) ? 5'h00 : 5'(p + 5'h01);
    endfunction
    // Mode byte to drive-mode fields
    function automatic ldc_mode_t decodeMode(input logic [7:0] b);
        decodeMode = '{frame160: b[`LDC_F_FRAME], oscRun: b[`LDC_F_OSC],
                       dispEn: b[`LDC_F_DISP], biasHalf: b[`LDC_F_BIAS]};
    endfunction

    // ---------------- Link domain ----------------
    logic        rstL1, rstL2;             // Reset brought into link domain
    logic        sclS1, sclS2, sclPrev;    // SCL synchroniser and history
    logic        sdaS1, sdaS2, sdaPrev;    // SDA synchroniser and history
    ldc_state_t  state_reg;                // Protocol state
    logic [3:0]  bitCnt_reg;               // Bit slot, 8 ack slot, 15 before first bit
    logic [7:0]  shift_reg;                // Received byte
    logic [7:0]  tx_reg;                   // Byte being sent
    logic        mAck_reg;                 // Master acked last read byte
    logic        rdFirst_reg;              // Next ack slot follows address
    logic        wrData_reg;               // Last byte was display data
    logic        sdaOe_reg;                // Pull-low enable
    logic [4:0]  ptr_reg;                  // Display address pointer
    logic [7:0]  ram [`LDC_RAM_DEPTH];     // Readback copy of display RAM
    ldc_xfer_t   xfer_reg;                 // Event word, held until next
    logic        xTgl_reg;                 // Event toggle

    // Reset synchroniser; first stage feeds only the second
    always_ff @(posedge clk_link) begin
        rstL1 <= reset;
        rstL2 <= rstL1;
    end

    // Pin synchronisers; edges are judged on second stage only
    always_ff @(posedge clk_link) begin
        sclS1   <= sclIn;
        sclS2   <= sclS1;
        sclPrev <= sclS2;
        sdaS1   <= sdaIn;
        sdaS2   <= sdaS1;
        sdaPrev <= sdaS2;
    end

    // Line events, all judged on synchronised levels
    // Read data looks one location ahead once the first byte is out
    logic startDet, stopDet, sclRise, sclFall, byteDone, ackDone, addrHit;
    logic [7:0] rdData;
    always_comb begin
        startDet = sclS2 && sclPrev && sdaPrev && !sdaS2;
        stopDet  = sclS2 && sclPrev && !sdaPrev && sdaS2;
        sclRise  = sclS2 && !sclPrev;
        sclFall  = !sclS2 && sclPrev && (state_reg != ST_IDLE);
        byteDone = sclFall && (bitCnt_reg == 4'h7);
        ackDone  = sclFall && (bitCnt_reg == 4'h8);
        addrHit  = (shift_reg[7:1] == `LDC_DEV_ADDR);
        rdData   = rdFirst_reg ? ram[ptr_reg] : ram[nextPtr(ptr_reg)];
    end

    // Protocol state and bit slot; START wins over everything
    always_ff @(posedge clk_link) begin
        if (rstL2) begin
            state_reg  <= ST_IDLE;
            bitCnt_reg <= 4'h0;
        end else if (startDet) begin
            // SCL still falls once after START; parking at 15
            // makes that fall wrap the count to slot 0, not slot 1
            state_reg  <= ST_ADDR;
            bitCnt_reg <= 4'hf;
        end else if (stopDet) begin
            state_reg  <= ST_IDLE;
        end else if (sclFall) begin
            bitCnt_reg <= (bitCnt_reg == 4'h8) ? 4'h0 : 4'(bitCnt_reg + 4'h1);
            if (byteDone) begin
                case (state_reg)
                    ST_ADDR: begin
                        // Direction bit selects read or write
                        state_reg <= !addrHit ? ST_IDLE : (shift_reg[0] ? ST_READ : ST_WFIRST);
                    end
                    ST_WFIRST: begin
                        // Commands and undefined bytes swallow the rest
                        state_reg <= isPtr(shift_reg) ? ST_WDATA : ST_DISCARD;
                    end
                    default: ;
                endcase
            end else if (ackDone && state_reg == ST_READ && !mAck_reg && !rdFirst_reg) begin
                state_reg <= ST_IDLE;
            end
        end
    end

    // Bit capture on rising SCL, MSB first
    always_ff @(posedge clk_link) begin
        if (rstL2) begin
            shift_reg <= 8'h00;
            mAck_reg  <= 1'b0;
        end else if (sclRise && bitCnt_reg < 4'h8) begin
            shift_reg <= {shift_reg[6:0], sdaS2};
        end else if (sclRise) begin
            mAck_reg  <= !sdaS2;
        end
    end

    // SDA drive and transmit shifter, changed on SCL falls; START and STOP release the drive
    always_ff @(posedge clk_link) begin
        if (rstL2) begin
            sdaOe_reg   <= 1'b0;
            tx_reg      <= 8'h00;
            rdFirst_reg <= 1'b0;
        end else if (startDet || stopDet) begin
            sdaOe_reg   <= 1'b0;
            rdFirst_reg <= 1'b0;
        end else if (byteDone) begin
            // Ack held low across the whole ninth clock
            case (state_reg)
                ST_ADDR:                        sdaOe_reg <= addrHit;
                ST_WFIRST, ST_WDATA, ST_DISCARD: sdaOe_reg <= 1'b1;
                default:                        sdaOe_reg <= 1'b0;
            endcase
            rdFirst_reg <= (state_reg == ST_ADDR) && addrHit && shift_reg[0];
        end else if (ackDone) begin
            rdFirst_reg <= 1'b0;
            if (state_reg == ST_READ && (rdFirst_reg || mAck_reg)) begin
                tx_reg    <= rdData;
                sdaOe_reg <= !rdData[7];
            end else begin
                sdaOe_reg <= 1'b0;
            end
        end else if (sclFall && state_reg == ST_READ) begin
            tx_reg    <= {tx_reg[6:0], 1'b0};
            sdaOe_reg <= !tx_reg[6];
        end
    end

    // Address pointer
    always_ff @(posedge clk_link) begin
        if (rstL2) begin
            ptr_reg    <= 5'h00;
            wrData_reg <= 1'b0;
        end else if (byteDone) begin
            wrData_reg <= (state_reg == ST_WDATA);
            if (state_reg == ST_WFIRST && isPtr(shift_reg)) begin
                ptr_reg <= shift_reg[4:0];
            end
        end else if (ackDone) begin
            if (wrData_reg || (state_reg == ST_READ && mAck_reg && !rdFirst_reg)) begin
                ptr_reg <= nextPtr(ptr_reg);
            end
            wrData_reg <= 1'b0;
        end
    end

    // Readback RAM, cleared at reset so reads are defined
    always_ff @(posedge clk_link) begin
        if (rstL2) begin
            for (int i = 0; i < `LDC_RAM_DEPTH; i++) begin
                ram[i] <= 8'h00;
            end
        end else if (byteDone && state_reg == ST_WDATA) begin
            ram[ptr_reg] <= shift_reg;
        end
    end

    // Event word to system side; held stable far longer than the sync delay
    always_ff @(posedge clk_link) begin
        if (rstL2) begin
            xfer_reg <= '0;
            xTgl_reg <= 1'b0;
        end else if (byteDone && state_reg == ST_WDATA) begin
            xfer_reg <= '{kind: XK_DATA, addr: ptr_reg, data: shift_reg};
            xTgl_reg <= !xTgl_reg;
        end else if (byteDone && state_reg == ST_WFIRST && isMode(shift_reg)) begin
            xfer_reg <= '{kind: XK_MODE, addr: 5'h00, data: shift_reg};
            xTgl_reg <= !xTgl_reg;
        end else if (byteDone && state_reg == ST_WFIRST && isBlink(shift_reg)) begin
            xfer_reg <= '{kind: XK_BLINK, addr: 5'h00, data: shift_reg};
            xTgl_reg <= !xTgl_reg;
        end
    end

    // Open drain: the pin is only ever pulled low
    assign sdaOut = 1'b0;
    assign sdaOe  = sdaOe_reg;

    // ---------------- System domain ----------------
    logic            tS1, tS2, tSeen;    // Toggle synchroniser
    ldc_mode_t       mode_reg;           // Drive mode
    logic [1:0]      blink_reg;          // Blink rate
    logic [MW-1:0]   map_reg;            // Display RAM as segment map
    logic [MW-1:0]   seg_reg;            // Gated segment drive
    logic [25:0]     bCnt_reg;           // Blink half-period counter
    logic            blank_reg;          // Blank phase of blink
    logic            newEvt, blinkOn;

    // Toggle crossing; first stage feeds only the second
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tS1   <= 1'b0;
            tS2   <= 1'b0;
            tSeen <= 1'b0;
        end else begin
            tS1   <= xTgl_reg;
            tS2   <= tS1;
            tSeen <= tS2;
        end
    end

    // A toggle change marks one new event word
    // Blinking only runs while the display is lit
    always_comb begin
        newEvt  = (tS2 != tSeen);
        blinkOn = (blink_reg != 2'h0) && mode_reg.oscRun && mode_reg.dispEn;
    end

    // Command registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mode_reg  <= decodeMode(`LDC_MODE_RST);
            blink_reg <= 2'(`LDC_BLINK_RST);
        end else if (newEvt && xfer_reg.kind == XK_MODE) begin
            mode_reg  <= decodeMode(xfer_reg.data);
        end else if (newEvt && xfer_reg.kind == XK_BLINK) begin
            blink_reg <= xfer_reg.data[1:0];
        end
    end

    // Segment map; byte n covers segments 2n and 2n+1
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            map_reg <= '0;
        end else if (newEvt && xfer_reg.kind == XK_DATA) begin
            map_reg[{xfer_reg.addr, 3'h0} +: 8] <= xfer_reg.data;
        end
    end

    // Half-period limit; slower rates use whole multiples of the 2 Hz half period
    function automatic logic [25:0] blinkLimit(input logic [1:0] sel);
        case (sel)
            2'h1:    blinkLimit = 26'(BLINK_HALF_CYC - 1);
            2'h2:    blinkLimit = 26'(BLINK_HALF_CYC * 2 - 1);
            default: blinkLimit = 26'(BLINK_HALF_CYC * 4 - 1);
        endcase
    endfunction

    // Blink timer; stops with the oscillator
    always_ff @(posedge clk_sys) begin
        if (reset || !blinkOn) begin
            bCnt_reg  <= 26'h0;
            blank_reg <= 1'b0;
        end else if (bCnt_reg >= blinkLimit(blink_reg)) begin
            bCnt_reg  <= 26'h0;
            blank_reg <= !blank_reg;
        end else begin
            bCnt_reg  <= 26'(bCnt_reg + 26'h1);
        end
    end

    // Displayed pattern; oscillator off blanks regardless of display bit
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            seg_reg <= '0;
        end else begin
            seg_reg <= (mode_reg.oscRun && mode_reg.dispEn && !blank_reg) ? map_reg : '0;
        end
    end

    // Outputs taken straight from registers
    assign modeCfg    = mode_reg;
    assign blinkSel   = blink_reg;
    assign blinkBlank = blank_reg;
    assign segDrive   = seg_reg;

    // ---------------- Checks ----------------
    // Link domain checks
    a_start_addr: assert property (@(posedge clk_link) disable iff (rstL2)
        startDet |=> state_reg == ST_ADDR && bitCnt_reg == 4'hf) else $error("start not taken");
    a_stop_idle: assert property (@(posedge clk_link) disable iff (rstL2)
        stopDet && !startDet |=> state_reg == ST_IDLE) else $error("stop not taken");
    a_addr_ack: assert property (@(posedge clk_link) disable iff (rstL2)
        byteDone && state_reg == ST_ADDR |=> sdaOe_reg == $past(addrHit)) else $error("address ack wrong");
    a_ack_held: assert property (@(posedge clk_link) disable iff (rstL2)
        byteDone && state_reg == ST_WDATA ##1 !sclFall[*3] |-> sdaOe_reg) else $error("ack dropped early");
    a_cmd_discard: assert property (@(posedge clk_link) disable iff (rstL2)
        byteDone && state_reg == ST_WFIRST && !isPtr(shift_reg) |=> state_reg == ST_DISCARD) else $error("no discard");
    a_ptr_wrap: assert property (@(posedge clk_link) disable iff (rstL2)
        ackDone && wrData_reg && ptr_reg == `LDC_PTR_MAX |=> ptr_reg == 5'h00) else $error("pointer did not wrap");
    a_rd_nack_hold: assert property (@(posedge clk_link) disable iff (rstL2)
        ackDone && state_reg == ST_READ && !mAck_reg && !rdFirst_reg |=> $stable(ptr_reg) && !sdaOe_reg)
        else $error("pointer moved on nack");
    a_rd_msb: assert property (@(posedge clk_link) disable iff (rstL2)
        ackDone && state_reg == ST_READ && rdFirst_reg |=> sdaOe_reg == !ram[ptr_reg][7]) else $error("bad msb");
    a_ram_store: assert property (@(posedge clk_link) disable iff (rstL2)
        byteDone && state_reg == ST_WDATA |=> ram[$past(ptr_reg)] == $past(shift_reg)) else $error("byte not stored");
    a_stop_release: assert property (@(posedge clk_link) disable iff (rstL2)
        stopDet |=> !sdaOe_reg) else $error("line held after stop");
    a_foreign_idle: assert property (@(posedge clk_link) disable iff (rstL2)
        byteDone && state_reg == ST_ADDR && !addrHit |=> state_reg == ST_IDLE) else $error("foreign address taken");
    // System domain checks
    a_reset_mode: assert property (@(posedge clk_sys)
        reset |=> mode_reg == '0 && blink_reg == 2'h0) else $error("bad reset mode");
    a_osc_blank: assert property (@(posedge clk_sys) disable iff (reset)
        !mode_reg.oscRun |=> seg_reg == '0) else $error("display not blanked");
    a_blink_flip: assert property (@(posedge clk_sys) disable iff (reset)
        blinkOn && bCnt_reg == blinkLimit(blink_reg) ##1 blinkOn |-> blank_reg != $past(blank_reg))
        else $error("blink did not flip");
    a_blink_apply: assert property (@(posedge clk_sys) disable iff (reset)
        newEvt && xfer_reg.kind == XK_BLINK |=> blink_reg == $past(xfer_reg.data[1:0])) else $error("blink not set");
    a_seg_show: assert property (@(posedge clk_sys) disable iff (reset)
        mode_reg.oscRun && mode_reg.dispEn && !blank_reg |=> seg_reg == $past(map_reg)) else $error("segments not shown");
    // Cover points for the main scenarios
    c_addr_hit: cover property (@(posedge clk_link) byteDone && state_reg == ST_ADDR && addrHit);
    c_ptr_wrap: cover property (@(posedge clk_link) ackDone && wrData_reg && ptr_reg == `LDC_PTR_MAX);
    c_read_ack: cover property (@(posedge clk_link) ackDone && state_reg == ST_READ && mAck_reg);
    c_mode_set: cover property (@(posedge clk_sys) newEvt && xfer_reg.kind == XK_MODE);
    c_blink: cover property (@(posedge clk_sys) $rose(blank_reg));
endmodule
`default_nettype wire

// file: design/ldc_params.svh
// Function
// - SDA falls while SCL high: START
// - SDA rises while SCL high: STOP
// - Repeated START handled exactly like START
// - Eight bits, MSB first, then acknowledge
// - Device pulls SDA low for ack
// - First byte: address plus direction bit
// - Acknowledge only a matching slave address
// - Byte write: address, location, data acknowledged
// - Byte after a command is discarded
// - Write data stored, pointer then incremented
// - Write pointer wraps top to zero
// - Read sends addressed byte MSB first
// - Read pointer advances after ack, wraps
// - Mode set decode: frame, oscillator, display, bias
// - Bias bit: zero third, one half
// - Oscillator off blanks; display bit gates
// - Frame bit: zero 80 Hz, one 160 Hz
// - Power-on: third bias, blank, stopped, 80 Hz
// - Undefined command data changes nothing
// - Pointer load from low five bits
// - Blink command sets two-bit rate
// - Blink rates 2, 1, 0.5 Hz
// - RAM bits map to segment/common pairs
`ifndef LDC_PARAMS_SVH
`define LDC_PARAMS_SVH
`define LDC_DEV_ADDR       7'h3f
`define LDC_RAM_DEPTH      22
`define LDC_PTR_MAX        5'h15
`define LDC_MODE_RST       8'h80
`define LDC_BLINK_RST      8'hc0
`define LDC_F_FRAME        4
`define LDC_F_OSC          3
`define LDC_F_DISP         2
`define LDC_F_CLR          1
`define LDC_F_BIAS         0
`define LDC_OP_PTR         3'h0
`define LDC_OP_MODE        3'h4
`define LDC_OP_BLINK       6'h30
`define LDC_CLK_SYS_KHZ    25000
`define LDC_BLINK_2HZ_MS   500
`endif

// file: design/ldc_pkg.sv
package ldc_pkg;
    // Link protocol states
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WFIRST, ST_WDATA, ST_DISCARD, ST_READ} ldc_state_t;
    // Kind of event passed to the system side
    typedef enum logic [1:0] {XK_DATA, XK_MODE, XK_BLINK} ldc_xkind_t;
    // Event word crossing the clock domains
    typedef struct packed {
        ldc_xkind_t  kind;
        logic [4:0]  addr;
        logic [7:0]  data;
    } ldc_xfer_t;
    // Decoded drive mode
    typedef struct packed {
        logic frame160;
        logic oscRun;
        logic dispEn;
        logic biasHalf;
    } ldc_mode_t;
endpackage

// file: sim/ldc_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none
module ldc_i2c_master (
    input  wire logic clk,     // Pacing clock
    input  wire logic sdaBus,  // Resolved SDA level
    output logic      sclOut,  // SCL level, master only
    output logic      sdaLow   // High while master pulls SDA low
);
    // Idle bus: both lines released
    initial begin
        sclOut = 1'b1;
        sdaLow = 1'b0;
    end
    // Wait whole cycles, changes land off the sampling edge
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    // One bit: data set while SCL low, sampled at end of high phase
    task automatic bitIo(input logic b, output logic s);
        wt(5);
        sdaLow = !b;
        wt(20);
        sclOut = 1'b1;
        wt(20);
        s = sdaBus;
        sclOut = 1'b0;
    endtask
    // START or repeated START; SDA is released first in both cases
    task automatic start();
        sdaLow = 1'b0;
        wt(20);
        sclOut = 1'b1;
        wt(20);
        sdaLow = 1'b1;
        wt(20);
        sclOut = 1'b0;
    endtask
    // STOP ends the transfer and leaves the bus free
    task automatic stop();
        wt(5);
        sdaLow = 1'b1;
        wt(20);
        sclOut = 1'b1;
        wt(20);
        sdaLow = 1'b0;
        wt(20);
    endtask
    // Byte MSB first; released bits (ones) let the device drive
    task automatic byteIo(input logic [7:0] tx, input logic mAck, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bitIo(tx[i], rx[i]);
        end
        // Ninth pulse: master acks reads, stays high on the last one
        bitIo(!mAck, ack);
    endtask
endmodule
`default_nettype wire

// file: sim/ldc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ldc_params.svh"
module ldc_top_tb import ldc_pkg::*;;
    logic                          clk_sys;    // System clock
    logic                          clk_link;   // Link sampling clock
    logic                          reset;      // Sync reset
    logic                          sclLine;    // SCL from master
    logic                          sdaLow;     // Master pull-low
    logic                          sdaLine;    // Resolved SDA
    logic                          sdaOut;     // Device drive value
    logic                          sdaOe;      // Device pull-low enable
    ldc_mode_t                     modeCfg;    // Decoded mode
    logic [1:0]                    blinkSel;   // Blink select
    logic                          blinkBlank; // Blank phase
    logic [8*`LDC_RAM_DEPTH-1:0]   segDrive;   // Segment map
    int                            failures;   // Mismatch count
    int                            num_checks; // Compare count
    int                            cyc;        // Timeout counter
    logic [7:0]                    rx;         // Read data
    logic                          ack;        // Ninth-bit level
    int                            rises;      // Blank rising edges
    logic                          prevBlank;  // Blank level one cycle earlier
    localparam logic [7:0] WADR = {`LDC_DEV_ADDR, 1'b0}; // Address with write
    localparam logic [7:0] RADR = {`LDC_DEV_ADDR, 1'b1}; // Address with read
    // Pull-up wire: low when either party pulls
    assign sdaLine = ((sdaOe && !sdaOut) || sdaLow) ? 1'b0 : 1'b1;
    // Short blink half period keeps the run brief
    ldc_top #(.BLINK_HALF_CYC(8)) ldc_top_i (
        .clk_sys(clk_sys), .reset(reset), .clk_link(clk_link), .sclIn(sclLine), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .modeCfg(modeCfg), .blinkSel(blinkSel),
        .blinkBlank(blinkBlank), .segDrive(segDrive));
    ldc_i2c_master ldc_i2c_master_i (.clk(clk_sys), .sdaBus(sdaLine), .sclOut(sclLine), .sdaLow(sdaLow));
    // Clocks, unrelated in phase
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = !clk_sys;
    end
    initial begin
        clk_link = 1'b0;
        #17;
        forever #62.5 clk_link = !clk_link;
    end
    // Compare and report
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Write one byte, expecting the given ninth-bit level
    task automatic wr(input logic [7:0] b, input logic expAck);
        ldc_i2c_master_i.byteIo(b, 1'b0, rx, ack);
        check({7'h0, ack}, {7'h0, expAck});
    endtask
    // Command transfer: address, command, one trailing byte
    task automatic cmd(input logic [7:0] c);
        ldc_i2c_master_i.start();
        wr(WADR, 1'b0);
        wr(c, 1'b0);
        wr(8'hff, 1'b0);
        ldc_i2c_master_i.stop();
        repeat (10) @(negedge clk_sys);
    endtask
    // Hang guard, roughly three times the expected run
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        reset = 1'b1;
        failures = 0;
        num_checks = 0;
        cyc = 0;
        // Held longer than 8 cycles so the link side sees 5 edges
        repeat (16) @(negedge clk_sys);
        reset = 1'b0;
        repeat (20) @(negedge clk_sys);
        check({4'h0, modeCfg}, 8'h00);
        check({6'h0, blinkSel}, 8'h00);
        check(segDrive[7:0], 8'h00);
        $display("test reset done");
        // Foreign address is ignored
        ldc_i2c_master_i.start();
        wr(8'h7c, 1'b1);
        ldc_i2c_master_i.stop();
        // Page write across the top location
        ldc_i2c_master_i.start();
        wr(WADR, 1'b0);
        wr(8'h14, 1'b0);
        wr(8'ha5, 1'b0);
        wr(8'h3c, 1'b0);
        wr(8'h81, 1'b0);
        ldc_i2c_master_i.stop();
        $display("test write done");
        // Mode set codes; trailing 0xff must be discarded
        cmd(8'h91);
        check({4'h0, modeCfg}, 8'h09);
        check(segDrive[8*20+:8], 8'h00);
        cmd(8'h88);
        check({4'h0, modeCfg}, 8'h04);
        check(segDrive[8*20+:8], 8'h00);
        cmd(8'h8c);
        check({4'h0, modeCfg}, 8'h06);
        check(segDrive[8*20+:8], 8'ha5);
        check(segDrive[8*21+:8], 8'h3c);
        check(segDrive[7:0], 8'h81);
        // Undefined encodings leave everything as it was
        cmd(8'h60);
        cmd(8'h8e);
        check({4'h0, modeCfg}, 8'h06);
        check(segDrive[8*21+:8], 8'h3c);
        $display("test mode done");
        // Pointer load, repeated START, read with wrap and final NACK
        ldc_i2c_master_i.start();
        wr(WADR, 1'b0);
        wr(8'h14, 1'b0);
        ldc_i2c_master_i.start();
        wr(RADR, 1'b0);
        ldc_i2c_master_i.byteIo(8'hff, 1'b1, rx, ack);
        check(rx, 8'ha5);
        ldc_i2c_master_i.byteIo(8'hff, 1'b1, rx, ack);
        check(rx, 8'h3c);
        ldc_i2c_master_i.byteIo(8'hff, 1'b0, rx, ack);
        check(rx, 8'h81);
        ldc_i2c_master_i.stop();
        $display("test read done");
        // Blink codes: rising edges of blank in 64 cycles follow the rate
        for (int k = 1; k <= 3; k++) begin
            cmd({6'h30, k[1:0]});
            check({6'h0, blinkSel}, {6'h0, k[1:0]});
            rises = 0;
            prevBlank = blinkBlank;
            for (int t = 0; t < 64; t++) begin
                @(negedge clk_sys);
                if (blinkBlank === 1'b1 && prevBlank === 1'b0)
                    rises++;
                // Segment drive follows the blank phase one cycle late
                check(segDrive[8*20+:8], (prevBlank === 1'b1) ? 8'h00 : 8'ha5);
                prevBlank = blinkBlank;
            end
            check(rises[7:0], 8'(4 >> (k - 1)));
        end
        cmd(8'hc0);
        repeat (40) @(negedge clk_sys);
        check({7'h0, blinkBlank}, 8'h00);
        check(segDrive[8*20+:8], 8'ha5);
        $display("test blink done");
        summarize();
    end
endmodule
`default_nettype wire
